// ---- usb_host_ctl_cfg.svh ----
// Constants for the bridge controller: register offsets, field positions and command codes.
`ifndef USB_HOST_CTL_CFG_SVH
`define USB_HOST_CTL_CFG_SVH
// Own registers seen by software over Avalon-MM (byte addresses).
`define HC_CTRL_OFS       5'h00
`define HC_START_OFS      5'h04
`define HC_END_OFS        5'h08
`define HC_CFG_OFS        5'h0C
`define HC_PRESET_OFS     5'h10
`define HC_STATUS_OFS     5'h14
`define HC_RESULT_OFS     5'h18
// Bridge register map reached through the device port (word index).
`define DV_CORE_SET       8'h00
`define DV_START          8'h01
`define DV_END            8'h02
`define DV_CHAN_SET       8'h03
`define DV_EXPIRY         8'h04
`define DV_RD_CUR         8'h05
`define DV_WR_CUR         8'h06
`define DV_EP_CMD         8'h07
`define DV_PWR_CTL        8'h08
`define DV_INT_STS        8'h09
// Field positions in the bridge registers.
`define EOP_EN_BIT        0
`define RD_EN_BIT         0
`define RD_ABORT_BIT      1
`define RD_RESET_BIT      2
`define WR_EN_BIT         4
`define WR_ABORT_BIT      5
`define WR_RESET_BIT      6
`define EXP_EN_BIT        31
`define SRST_N_BIT        0
`define SENSE_BIT         1
`define IS_RD_END         0
`define IS_WR_END         1
`define IS_IDLE_PKT       2
`define IS_WR_EXP         3
`define IS_PWR_DET        4
`define IS_BUS_RST        5
`define IS_BUS_RST_END    6
// Endpoint command codes in bits 3:0, endpoint number in bits 7:4.
`define CMD_READY         4'h1
`define CMD_EP_ON         4'h2
`define CMD_EP_OFF        4'h3
`define CMD_EP_FLUSH      4'h4
// Reset value of every own register.
`define HC_RST_VAL        32'h0000_0000
`endif

// ---- usb_host_ctl_pkg.sv ----
// Types shared by the bridge controller.
package usb_host_ctl_pkg;
  // Sequencer states, one bit changes on every move except load to finish, which flips both.
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOAD   = 2'b01,
    ST_ISSUE  = 2'b11,
    ST_FINISH = 2'b10
  } seq_state_e;
  // Procedures, lower index has higher priority.
  typedef enum logic [2:0] {
    P_IRQ  = 3'h0,
    P_INIT = 3'h1,
    P_RDAB = 3'h2,
    P_WRAB = 3'h3,
    P_RDST = 3'h4,
    P_WRST = 3'h5
  } proc_e;
  // Kind of one step.
  typedef enum logic [1:0] {
    K_END  = 2'h0,
    K_WR   = 2'h1,
    K_RD   = 2'h2,
    K_POLL = 2'h3
  } step_kind_e;
  // One access toward the bridge.
  typedef struct packed {
    logic        write;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } dev_req_s;
  // One decoded step of a procedure.
  typedef struct packed {
    step_kind_e  kind;
    dev_req_s    req;
    logic [31:0] mask;
  } step_s;
endpackage

// ---- usb_host_ctl.sv ----
// Controller that drives the USB DMA bridge through its register port.
//
// Local design decisions: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "usb_host_ctl_cfg.svh"
// Behaviour
// - EOP off needs multiple-of-packet totals
// - Program addresses, settings, then read enable
// - Read abort: endpoint off, abort, await clear
// - After read abort: block reset, flush, on
// - Odd packet size: even field, EOP on
// - Write start: addresses then write enable
// - Program expiry preset and enable before start
// - Write abort: off, abort, await, reset, flush
// - Soft reset set, then cleared by software
// - Ready command after setup; bus reset irqs
// - Power loss needs soft reset, not auto
// - Bus reset: abort running transfers
// - Reprogram only after bus reset end
module usb_host_ctl
  import usb_host_ctl_pkg::*;
(
  input  wire logic        mclk_i,             // System clock, 250 MHz.
  input  wire logic        rst_n_i,            // Synchronous reset, active low.
  input  wire logic [4:0]  avs_address_i,      // Byte address of own register.
  input  wire logic        avs_read_i,         // Avalon read request.
  input  wire logic        avs_write_i,        // Avalon write request.
  input  wire logic [31:0] avs_writedata_i,    // Avalon write data.
  output logic      [31:0] avs_readdata_o,     // Avalon read data.
  output logic             avs_waitrequest_o,  // Avalon stall.
  output logic             dev_req_valid_o,    // Access to the bridge pending.
  output dev_req_s         dev_req_o,          // Access to the bridge.
  input  wire logic        dev_ack_i,          // Bridge has taken the access.
  input  wire logic [31:0] dev_rdata_i,        // Bridge read data with ack.
  input  wire logic        usb_main_irq_i,     // Main interrupt, same clock.
  input  wire logic        power_on_irq_i,     // Power-on interrupt pin.
  input  wire logic        wake_irq_i          // Wake interrupt pin.
);

  // Software-visible configuration and status.
  logic [31:0] start_addr;         // Transfer start address.
  logic [31:0] end_addr;           // Transfer end address.
  logic [31:0] cfg;                // Bit 0 EOP, bit 1 expiry enable, 7:4 endpoint.
  logic [31:0] preset;             // Expiry preset.
  logic [31:0] result;             // Captured current address.
  logic [7:0]  flags;              // Sticky status flags.
  logic        rd_active;          // Read channel believed running.
  logic        wr_active;          // Write channel believed running.
  logic [5:0]  pend;               // Procedures waiting to run.
  logic        rd_pend;            // Read data phase in progress.
  // Sequencer.
  seq_state_e  state;              // Sequencer state.
  proc_e       proc;               // Procedure running.
  logic [2:0]  idx;                // Step index.
  step_s       step;               // Decoded current step.
  logic [31:0] snap;               // Captured interrupt status.
  logic [31:0] pwr;                // Captured power control word.
  // Pin synchronisers for the two interrupt pins.
  logic [2:0]  pon_sync;           // Power-on pin stages.
  logic [2:0]  wak_sync;           // Wake pin stages.
  logic        pon_lvl;            // Filtered power-on level.
  logic        wak_lvl;            // Filtered wake level.
  logic        pon_lvl_q;          // Previous filtered level.
  logic        wak_lvl_q;          // Previous filtered level.

  // Decoding of the Avalon access.
  wire ctrl_wr   = avs_write_i && (avs_address_i == `HC_CTRL_OFS);
  wire status_wr = avs_write_i && (avs_address_i == `HC_STATUS_OFS);
  wire take_rd   = avs_read_i && !rd_pend;
  wire [3:0] ep  = cfg[7:4];
  wire pon_rise  = pon_lvl && !pon_lvl_q;
  wire wak_rise  = wak_lvl && !wak_lvl_q;
  wire step_done = (state == ST_ISSUE) && dev_ack_i;
  wire poll_busy = (step.kind == K_POLL) && ((dev_rdata_i & step.mask) != 32'h0000_0000);
  wire irq_end   = (state == ST_FINISH) && (proc == P_IRQ);
  wire [2:0] pick = first_set(pend);

  // Returns the index of the lowest pending procedure.
  function automatic logic [2:0] first_set(input logic [5:0] v);
    first_set = 3'h7;
    for (int i = 5; i >= 0; i--) begin
      if (v[i]) begin
        first_set = 3'(i);
      end
    end
  endfunction

  // Builds an endpoint command word.
  function automatic logic [31:0] ep_cmd(input logic [3:0] code, input logic [3:0] num);
    ep_cmd = {24'h00_0000, num, code};
  endfunction

  // Step table: what each procedure does at each index.
  always_comb begin
    step = '{kind: K_END, req: '0, mask: 32'h0000_0000};
    unique case (proc)
      P_INIT: begin
        unique case (idx)
          3'h0: step = '{K_WR, '{1'b1, `DV_PWR_CTL, 32'h0000_0000}, 32'h0};
          3'h1: step = '{K_WR, '{1'b1, `DV_PWR_CTL, 32'h0000_0001}, 32'h0};
          3'h2: step = '{K_WR, '{1'b1, `DV_CORE_SET, {31'h0, cfg[0]}}, 32'h0};
          3'h3: step = '{K_WR, '{1'b1, `DV_EP_CMD, ep_cmd(`CMD_READY, ep)}, 32'h0};
          default: step.kind = K_END;
        endcase
      end
      P_RDST: begin
        unique case (idx)
          3'h0: step = '{K_WR, '{1'b1, `DV_START, start_addr}, 32'h0};
          3'h1: step = '{K_WR, '{1'b1, `DV_END, end_addr}, 32'h0};
          3'h2: step = '{K_WR, '{1'b1, `DV_CORE_SET, {31'h0, cfg[0]}}, 32'h0};
          3'h3: step = '{K_WR, '{1'b1, `DV_CHAN_SET, 32'h0000_0001}, 32'h0};
          default: step.kind = K_END;
        endcase
      end
      P_WRST: begin
        unique case (idx)
          3'h0: step = '{K_WR, '{1'b1, `DV_EXPIRY, {cfg[1], preset[30:0]}}, 32'h0};
          3'h1: step = '{K_WR, '{1'b1, `DV_START, start_addr}, 32'h0};
          3'h2: step = '{K_WR, '{1'b1, `DV_END, end_addr}, 32'h0};
          3'h3: step = '{K_WR, '{1'b1, `DV_CHAN_SET, 32'h0000_0010}, 32'h0};
          default: step.kind = K_END;
        endcase
      end
      P_RDAB, P_WRAB: begin
        unique case (idx)
          3'h0: step = '{K_WR, '{1'b1, `DV_EP_CMD, ep_cmd(`CMD_EP_OFF, ep)}, 32'h0};
          3'h1: step = '{K_WR, '{1'b1, `DV_CHAN_SET,
                  (proc == P_RDAB) ? 32'h0000_0002 : 32'h0000_0020}, 32'h0};
          3'h2: step = '{K_POLL, '{1'b0, `DV_CHAN_SET, 32'h0},
                  (proc == P_RDAB) ? 32'h0000_0001 : 32'h0000_0010};
          3'h3: step = '{K_RD, '{1'b0, (proc == P_RDAB) ? `DV_RD_CUR : `DV_WR_CUR,
                  32'h0}, 32'h0};
          3'h4: step = '{K_WR, '{1'b1, `DV_CHAN_SET,
                  (proc == P_RDAB) ? 32'h0000_0004 : 32'h0000_0040}, 32'h0};
          3'h5: step = '{K_WR, '{1'b1, `DV_EP_CMD, ep_cmd(`CMD_EP_FLUSH, ep)}, 32'h0};
          3'h6: step = '{K_WR, '{1'b1, `DV_EP_CMD, ep_cmd(`CMD_EP_ON, ep)}, 32'h0};
          default: step.kind = K_END;
        endcase
      end
      P_IRQ: begin
        unique case (idx)
          3'h0: step = '{K_RD, '{1'b0, `DV_INT_STS, 32'h0}, 32'h0};
          3'h1: step = '{K_WR, '{1'b1, `DV_INT_STS, snap}, 32'h0};
          3'h2: step = '{K_RD, '{1'b0, `DV_PWR_CTL, 32'h0}, 32'h0};
          default: step.kind = K_END;
        endcase
      end
      default: step.kind = K_END;
    endcase
  end

  // Pin inputs pass three stages; a level counts once the last two agree.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pon_sync  <= 3'h0;
      wak_sync  <= 3'h0;
      pon_lvl   <= 1'b0;
      wak_lvl   <= 1'b0;
      pon_lvl_q <= 1'b0;
      wak_lvl_q <= 1'b0;
    end else begin
      pon_sync  <= {pon_sync[1:0], power_on_irq_i};
      wak_sync  <= {wak_sync[1:0], wake_irq_i};
      pon_lvl   <= (pon_sync[2] == pon_sync[1]) ? pon_sync[2] : pon_lvl;
      wak_lvl   <= (wak_sync[2] == wak_sync[1]) ? wak_sync[2] : wak_lvl;
      pon_lvl_q <= pon_lvl;
      wak_lvl_q <= wak_lvl;
    end
  end

  // Sequencer: loads a step, issues it, and walks the procedure to its end.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      state     <= ST_IDLE;
      proc      <= P_IRQ;
      idx       <= 3'h0;
      dev_req_o <= '0;
      snap      <= 32'h0000_0000;
      pwr       <= 32'h0000_0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (pick != 3'h7) begin
            proc  <= proc_e'(pick);
            idx   <= 3'h0;
            state <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          dev_req_o <= step.req;
          state     <= (step.kind == K_END) ? ST_FINISH : ST_ISSUE;
        end
        ST_ISSUE: begin
          if (dev_ack_i) begin
            // A poll that still sees the enable bit repeats the same read.
            idx   <= poll_busy ? idx : idx + 3'h1;
            state <= ST_LOAD;
            if (proc == P_IRQ && idx == 3'h0) begin
              snap <= dev_rdata_i;
            end
            if (proc == P_IRQ && idx == 3'h2) begin
              pwr <= dev_rdata_i;
            end
          end
        end
        ST_FINISH: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Access toward the bridge is valid for the whole issue phase.
  assign dev_req_valid_o = (state == ST_ISSUE);

  // Pending procedures: set by software, interrupts and pins; cleared when started.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pend <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (state == ST_IDLE && pick == 3'(i)) begin
          pend[i] <= 1'b0;
        end
      end
      if (ctrl_wr && avs_writedata_i[2:0] < 3'h6) begin
        pend[avs_writedata_i[2:0]] <= 1'b1;
      end
      if (usb_main_irq_i || wak_rise) begin
        pend[P_IRQ] <= 1'b1;
      end
      if (pon_rise) begin
        pend[P_INIT] <= 1'b1;
      end
      if (irq_end && snap[`IS_PWR_DET]) begin
        pend[P_INIT] <= 1'b1;
      end
      if (irq_end && snap[`IS_BUS_RST] && rd_active) begin
        pend[P_RDAB] <= 1'b1;
      end
      if (irq_end && snap[`IS_BUS_RST] && wr_active) begin
        pend[P_WRAB] <= 1'b1;
      end
    end
  end

  // Channel activity follows starts, end interrupts and aborts.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_active <= 1'b0;
      wr_active <= 1'b0;
    end else begin
      if (state == ST_FINISH && proc == P_RDST) begin
        rd_active <= 1'b1;
      end else if ((irq_end && snap[`IS_RD_END]) || (state == ST_FINISH && proc == P_RDAB)) begin
        rd_active <= 1'b0;
      end
      if (state == ST_FINISH && proc == P_WRST) begin
        wr_active <= 1'b1;
      end else if ((irq_end && (snap[`IS_WR_END] || snap[`IS_WR_EXP]))
                   || (state == ST_FINISH && proc == P_WRAB)) begin
        wr_active <= 1'b0;
      end
    end
  end

  // Sticky flags: 0 read end, 1 write end, 2 idle packet, 3 expiry,
  // 4 power lost, 5 bus reset, 6 reprogram allowed, 7 procedure done.
  // A new event wins over a software clear in the same cycle.
  wire [7:0] set_f = {state == ST_FINISH && proc != P_IRQ,
                      irq_end && snap[`IS_BUS_RST_END],
                      irq_end && snap[`IS_BUS_RST],
                      irq_end && snap[`IS_PWR_DET] && !pwr[`SENSE_BIT],
                      irq_end && snap[`IS_WR_EXP],
                      irq_end && snap[`IS_IDLE_PKT],
                      irq_end && snap[`IS_WR_END],
                      irq_end && snap[`IS_RD_END]};
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flags <= 8'h00;
    end else begin
      flags <= set_f | (flags & ~(status_wr ? avs_writedata_i[7:0] : 8'h00));
    end
  end

  // Software registers and the captured current address.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      start_addr <= `HC_RST_VAL;
      end_addr   <= `HC_RST_VAL;
      cfg        <= `HC_RST_VAL;
      preset     <= `HC_RST_VAL;
      result     <= `HC_RST_VAL;
    end else begin
      if (avs_write_i && avs_address_i == `HC_START_OFS) begin
        start_addr <= avs_writedata_i;
      end
      if (avs_write_i && avs_address_i == `HC_END_OFS) begin
        end_addr <= avs_writedata_i;
      end
      if (avs_write_i && avs_address_i == `HC_CFG_OFS) begin
        cfg <= avs_writedata_i;
      end
      if (avs_write_i && avs_address_i == `HC_PRESET_OFS) begin
        preset <= avs_writedata_i;
      end
      if (step_done && step.kind == K_RD && proc != P_IRQ) begin
        result <= dev_rdata_i;
      end
    end
  end

  // Read data is registered, so every read stalls one cycle.
  wire [31:0] rd_mux =
    (avs_address_i == `HC_CTRL_OFS)   ? {26'h0, pend} :
    (avs_address_i == `HC_START_OFS)  ? start_addr :
    (avs_address_i == `HC_END_OFS)    ? end_addr :
    (avs_address_i == `HC_CFG_OFS)    ? cfg :
    (avs_address_i == `HC_PRESET_OFS) ? preset :
    (avs_address_i == `HC_STATUS_OFS) ? {22'h0, wr_active, rd_active, flags} :
    (avs_address_i == `HC_RESULT_OFS) ? result : 32'h0000_0000;
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      rd_pend        <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      rd_pend <= take_rd;
      if (take_rd) begin
        avs_readdata_o <= rd_mux;
      end
    end
  end
  assign avs_waitrequest_o = take_rd;

  // Checks on the behaviour above.
  sequence abort_issued;
    step_done && (proc == P_RDAB || proc == P_WRAB) && idx == 3'h1;
  endsequence
  sequence init_clear;
    step_done && proc == P_INIT && idx == 3'h0;
  endsequence
  a_req_held: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dev_req_valid_o && !dev_ack_i |=> dev_req_valid_o && $stable(dev_req_o))
    else $error("access to bridge changed before ack");
  a_abort_poll_wait: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    step_done && idx == 3'h2 && (proc == P_RDAB || proc == P_WRAB) && poll_busy
    |=> idx == 3'h2 ##1 dev_req_o.addr == `DV_CHAN_SET && !dev_req_o.write)
    else $error("abort advanced while enable still set");
  a_abort_then_poll: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    abort_issued |=> ##1 dev_req_valid_o && !dev_req_o.write)
    else $error("abort not followed by enable poll");
  a_soft_reset_pair: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    init_clear |=> ##1 dev_req_o.addr == `DV_PWR_CTL && dev_req_o.wdata[`SRST_N_BIT])
    else $error("soft reset not released by second write");
  a_ready_cmd: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dev_req_valid_o && proc == P_INIT && idx == 3'h3
    |-> dev_req_o.wdata[3:0] == `CMD_READY && dev_req_o.addr == `DV_EP_CMD)
    else $error("ready command missing after setup");
  a_enable_last: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dev_req_valid_o && proc == P_RDST |-> (idx == 3'h3) == dev_req_o.wdata[`RD_EN_BIT]
      || dev_req_o.addr != `DV_CHAN_SET)
    else $error("read enable written out of order");
  a_expiry_first: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    dev_req_valid_o && proc == P_WRST && idx == 3'h0 |-> dev_req_o.addr == `DV_EXPIRY
      && dev_req_o.wdata[`EXP_EN_BIT] == cfg[1])
    else $error("expiry not programmed before write start");
  a_bus_reset_abort: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_end && snap[`IS_BUS_RST] && rd_active |=> pend[P_RDAB] || proc == P_RDAB)
    else $error("bus reset did not queue read abort");
  a_power_loss_init: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    irq_end && snap[`IS_PWR_DET] |=> pend[P_INIT] ##1 flags[4] || pwr[`SENSE_BIT])
    else $error("power change did not queue soft reset");
  a_read_answer: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
    take_rd |=> !avs_waitrequest_o && avs_readdata_o == $past(rd_mux))
    else $error("read answer late or wrong");

endmodule // usb_host_ctl

// ---- usb_bridge_model.sv ----
// Behavioural bridge register port that answers the controller.
`timescale 1ns/1ps
module usb_bridge_model
  import usb_host_ctl_pkg::*;
(
  input  wire logic        mclk_i,         // System clock.
  input  wire logic        rst_n_i,        // Synchronous reset, active low.
  input  wire logic        dev_req_valid_i,// Access pending from the controller.
  input  wire dev_req_s    dev_req_i,      // Access itself.
  input  wire logic        stall_i,        // Holds the answer back this cycle.
  input  wire logic [6:0]  raise_i,        // Interrupt sources raised by the bench.
  output logic             dev_ack_o,      // One-cycle answer.
  output logic      [31:0] dev_rdata_o,    // Read data with the answer.
  output logic             usb_main_irq_o  // Main interrupt level.
);
  logic [31:0] regs [16];  // Register file by word index.
  logic [2:0]  rd_cnt;     // Delay before a read abort lands.
  logic [2:0]  wr_cnt;     // Delay before a write abort lands.
  wire         take = dev_req_valid_i && !stall_i && !dev_ack_o;  // Access accepted now.
  assign usb_main_irq_o = |regs[9];
  // Accepts accesses, keeps the register file and lets enables fall after an abort.
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      foreach (regs[i]) regs[i] <= 32'h0;
      regs[5] <= 32'h0000_1234;
      regs[6] <= 32'h0000_5678;
      rd_cnt <= 3'h0;
      wr_cnt <= 3'h0;
      dev_ack_o <= 1'b0;
      dev_rdata_o <= 32'h0;
    end else begin
      dev_ack_o <= take;
      dev_rdata_o <= ~dev_rdata_o;  // Data are not held outside an answer.
      regs[9] <= regs[9] | {25'h0, raise_i};
      rd_cnt <= (rd_cnt != 3'h0) ? rd_cnt - 3'h1 : 3'h0;
      wr_cnt <= (wr_cnt != 3'h0) ? wr_cnt - 3'h1 : 3'h0;
      if (rd_cnt == 3'h1) regs[3][0] <= 1'b0;
      if (wr_cnt == 3'h1) regs[3][4] <= 1'b0;
      if (raise_i[3]) regs[3][4] <= 1'b0;
      if (take && !dev_req_i.write) dev_rdata_o <= regs[dev_req_i.addr[3:0]];
      if (take && dev_req_i.write) begin
        case (dev_req_i.addr[3:0])
          4'h3: begin
            regs[3] <= regs[3] | (dev_req_i.wdata & 32'h0000_0011);
            if (dev_req_i.wdata[1]) rd_cnt <= 3'h4;
            if (dev_req_i.wdata[5]) wr_cnt <= 3'h4;
          end
          4'h9: regs[9] <= (regs[9] & ~dev_req_i.wdata) | {25'h0, raise_i};
          default: regs[dev_req_i.addr[3:0]] <= dev_req_i.wdata;
        endcase
      end
    end
  end
endmodule // usb_bridge_model

// ---- tb.sv ----
// Self-checking bench for the bridge controller.
`timescale 1ns/1ps
module tb;
  import usb_host_ctl_pkg::*;
  logic        mclk_i = 0, rst_n_i = 0, avs_read_i = 0, avs_write_i = 0;
  logic [4:0]  avs_address_i = 5'h00;
  logic [31:0] avs_writedata_i = 32'h0, avs_readdata_o, dev_rdata_i, rd, sa, ea, pre;
  logic        avs_waitrequest_o, dev_req_valid_o, dev_ack_i, usb_main_irq_i;
  logic        power_on_irq_i = 0, wake_irq_i = 0, stall = 0;
  logic [6:0]  raise = 7'h00;
  logic [7:0]  cfg;
  dev_req_s    dev_req_o;
  logic [39:0] expq[$];  // Bridge writes the reference predicts.
  int          miscompares = 0, n_tests = 0, seed = 32'h196f, k, q;
  always #2 mclk_i = ~mclk_i;
  usb_host_ctl u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .dev_req_valid_o(dev_req_valid_o), .dev_req_o(dev_req_o), .dev_ack_i(dev_ack_i),
    .dev_rdata_i(dev_rdata_i), .usb_main_irq_i(usb_main_irq_i),
    .power_on_irq_i(power_on_irq_i), .wake_irq_i(wake_irq_i));
  usb_bridge_model u_bridge (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .dev_req_valid_i(dev_req_valid_o), .dev_req_i(dev_req_o), .stall_i(stall),
    .raise_i(raise), .dev_ack_o(dev_ack_i), .dev_rdata_o(dev_rdata_i),
    .usb_main_irq_o(usb_main_irq_i));
  // The bridge answers after a random number of cycles.
  always @(posedge mclk_i) stall <= 1'($random(seed));
  // Compares one value with its expectation.
  task chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Every accepted bridge write must be the next predicted one.
  always @(posedge mclk_i) if (rst_n_i && dev_req_valid_o && dev_ack_i && dev_req_o.write) begin
    if (expq.size() == 0) chk("extra write", {dev_req_o.addr, dev_req_o.wdata}, '1);
    else chk("bridge write", {dev_req_o.addr, dev_req_o.wdata},
             expq.pop_front());
  end
  // Prints the counts and the verdict, then stops.
  task give_verdict;
    $display("counts: %0d compared, %0d mismatched", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // One Avalon access, held until waitrequest is seen low.
  task av(input logic wr, input logic [4:0] a, input logic [31:0] d);
    k = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= wr;
    avs_read_i <= !wr;
    do begin @(posedge mclk_i); k++; end while (avs_waitrequest_o !== 1'b0 && k < 100);
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge mclk_i);
    if (k >= 100) begin miscompares++; give_verdict; end
  endtask
  task push(input logic [7:0] a, input logic [31:0] d);
    expq.push_back({a, d});
  endtask
  // Soft reset set and released, core setting, then the ready command.
  task exp_init;
    push(8'h08, 32'h0);
    push(8'h08, 32'h1);
    push(8'h00, {31'h0, cfg[0]});
    push(8'h07, {24'h0, cfg[7:4], 4'h1});
  endtask
  // Endpoint off, abort, block reset, flush, endpoint on; w picks the channel.
  task exp_abort(input int w);
    push(8'h07, {24'h0, cfg[7:4], 4'h3});
    push(8'h03, 32'h2 << (4 * w));
    push(8'h03, 32'h4 << (4 * w));
    push(8'h07, {24'h0, cfg[7:4], 4'h4});
    push(8'h07, {24'h0, cfg[7:4], 4'h2});
  endtask
  // Waits, bounded, until all predicted writes came and the port stays quiet.
  task settle;
    q = 0;
    for (k = 0; k < 4000 && q < 12; k++) begin
      @(posedge mclk_i);
      q = (expq.size() == 0 && dev_req_valid_o === 1'b0) ? q + 1 : 0;
    end
    if (q < 12) begin miscompares++; give_verdict; end
  endtask
  // Reads STATUS, checks it, clears the flags and reports the test.
  task stat(input string nm, input logic [31:0] e);
    settle;
    av(1'b0, 5'h14, 32'h0);
    chk(nm, {8'h0, rd & 32'h3FF}, {8'h0, e});
    av(1'b1, 5'h14, 32'hFF);
    $display("test %s done", nm);
  endtask
  initial begin
    repeat (4) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    @(posedge mclk_i);
    chk("reset readdata", {8'h0, avs_readdata_o}, 40'h0);
    stat("reset", 32'h0);
    cfg = 8'($random(seed)) & 8'hF0;  // Read packing with no end-of-packet.
    av(1'b1, 5'h0C, {24'h0, cfg});
    exp_init;
    av(1'b1, 5'h00, 32'h1);
    stat("init", 32'h80);
    sa = $random(seed);
    ea = sa + 32'h7F;  // Two whole 64-byte packets.
    av(1'b1, 5'h04, sa);
    av(1'b1, 5'h08, ea);
    push(8'h01, sa); push(8'h02, ea); push(8'h00, 32'h0); push(8'h03, 32'h1);
    av(1'b1, 5'h00, 32'h4);
    stat("read start", 32'h180);
    cfg[1] = 1'b1;
    pre = $random(seed);
    av(1'b1, 5'h0C, {24'h0, cfg});
    av(1'b1, 5'h10, pre);
    push(8'h04, {1'b1, pre[30:0]}); push(8'h01, sa); push(8'h02, ea); push(8'h03, 32'h10);
    av(1'b1, 5'h00, 32'h5);
    stat("write start", 32'h380);
    push(8'h09, 32'h64);
    push(8'h09, 32'h0);  // The interrupt level queued a second, empty service.
    exp_abort(0);
    exp_abort(1);
    raise <= 7'h64;
    @(posedge mclk_i);
    raise <= 7'h00;
    stat("bus reset", 32'hE4);
    av(1'b0, 5'h18, 32'h0);
    chk("stop address", {8'h0, rd}, 40'h0000005678);
    push(8'h09, 32'h10);
    push(8'h09, 32'h0);  // The empty second service runs before init.
    exp_init;
    raise <= 7'h10;
    @(posedge mclk_i);
    raise <= 7'h00;
    stat("power detect", 32'h90);
    exp_init;
    power_on_irq_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    power_on_irq_i <= 1'b0;
    stat("power pin", 32'h80);
    push(8'h09, 32'h0);
    wake_irq_i <= 1'b1;
    repeat (6) @(posedge mclk_i);
    wake_irq_i <= 1'b0;
    stat("wake pin", 32'h0);
    push(8'h04, {1'b1, pre[30:0]}); push(8'h01, sa); push(8'h02, ea); push(8'h03, 32'h10);
    av(1'b1, 5'h00, 32'h5);
    stat("write restart", 32'h280);
    push(8'h09, 32'h8);
    push(8'h09, 32'h0);  // The empty second service follows.
    raise <= 7'h08;
    @(posedge mclk_i);
    raise <= 7'h00;
    stat("write expiry", 32'h8);
    av(1'b1, 5'h00, 32'h7);
    av(1'b0, 5'h1C, 32'h0);
    chk("unmapped", {8'h0, rd}, 40'h0);
    stat("refused", 32'h0);
    give_verdict;
  end
endmodule // tb
